// ### logic/psr_defs.svh
// constants for the parallel access shift register
`ifndef PSR_DEFS_SVH
`define PSR_DEFS_SVH

`define PSR_STAGES 4
`define PSR_STAGE_RESET 4'h0
`define PSR_FIFO_DEPTH 8
`define PSR_SYNC_DEPTH 2
`define PSR_STAGE0_BIT 0
`define PSR_STAGE3_BIT 3

`endif

// ### logic/psr_pkg.sv
// types for the parallel access shift register
`default_nettype none

package psr_pkg;

    // pin group sampled from the driving logic
    typedef struct packed {
        logic reg_clk;
        logic clear_n;
        logic shift;
        logic load;
        logic serial;
        logic [3:0] par;
    } psr_pins_t;

    // operation taken at a falling register clock edge
    typedef enum logic [1:0] {
        PSR_HOLD = 2'b00,
        PSR_SHIFT = 2'b01,
        PSR_LOAD = 2'b10
    } psr_mode_t;

endpackage

`default_nettype wire

// ### logic/psr_sync.sv
// two flip-flop synchroniser for a group of pin levels
`timescale 1ns/1ps
`default_nettype none

module psr_sync #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // levels
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] meta;

    // first stage, read only by the second
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= '0;
        end else begin
            meta <= d;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= meta;
        end
    end

endmodule // psr_sync

`default_nettype wire

// ### logic/psr_fifo.sv
// synchronous fifo with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none

module psr_fifo #(
    parameter int WIDTH = 4,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);

    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic push;
    logic pop;

    assign in_ready = (count != (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data = mem[rd_ptr];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // storage
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    // pointers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
        end
    end

    // fill level
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= '0;
        end else if (push && !pop) begin
            count <= count + 1'b1;
        end else if (pop && !push) begin
            count <= count - 1'b1;
        end
    end

endmodule // psr_fifo

`default_nettype wire

// ### logic/psr_top.sv
// four stage parallel access shift register with snapshot stream
// Functional notes
// - contents change only on falling register clock or while clear is low
// - shift low, load high: copy parallel inputs
// - during load serial input is ignored
// - shift high shifts right, load ignored
// - first stage takes serial, others previous stage
// - shift and load low: contents held
// - clear low forces all stages low
// - inverted output mirrors fourth stage inverse
// - clear and inverted output only in variant
`timescale 1ns/1ps
`default_nettype none
`include "psr_defs.svh"

module psr_top #(
    parameter bit HAS_CLEAR = 1'b1,
    parameter int STAGES = `PSR_STAGES,
    parameter int FIFO_DEPTH = `PSR_FIFO_DEPTH
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // register pins from the driving logic
    input wire logic reg_clk,
    input wire logic clear_n,
    input wire logic shift,
    input wire logic load,
    input wire logic serial_in,
    input wire logic [3:0] par_in,
    // stage outputs
    output logic stage0_out,
    output logic stage1_out,
    output logic stage2_out,
    output logic stage3_out,
    output logic stage3_out_inverted,
    // snapshot stream after each operation
    output logic snap_valid,
    input wire logic snap_ready,
    output logic [3:0] snap_data,
    output logic snap_accept,
    output logic snap_dropped
);

    // ------------------------------------------------------------
    // pin synchronisation
    // ------------------------------------------------------------

    psr_pkg::psr_pins_t pins_raw;
    psr_pkg::psr_pins_t pins;

    assign pins_raw.reg_clk = reg_clk;
    assign pins_raw.clear_n = HAS_CLEAR ? clear_n : 1'b1;
    assign pins_raw.shift = shift;
    assign pins_raw.load = load;
    assign pins_raw.serial = serial_in;
    assign pins_raw.par = par_in;

    psr_sync #(
        .W($bits(psr_pkg::psr_pins_t))
    ) u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .d(pins_raw),
        .q(pins)
    );

    // ------------------------------------------------------------
    // falling edge detection
    // ------------------------------------------------------------

    logic reg_clk_prev;
    logic fall;
    logic clr_active;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_clk_prev <= 1'b0;
        end else begin
            reg_clk_prev <= pins.reg_clk;
        end
    end

    assign fall = reg_clk_prev && !pins.reg_clk;
    assign clr_active = HAS_CLEAR && !pins.clear_n;

    // ------------------------------------------------------------
    // mode decode
    // ------------------------------------------------------------

    psr_pkg::psr_mode_t mode;

    always_comb begin
        if (pins.shift) begin
            mode = psr_pkg::PSR_SHIFT;
        end else if (pins.load) begin
            mode = psr_pkg::PSR_LOAD;
        end else begin
            mode = psr_pkg::PSR_HOLD;
        end
    end

    // ------------------------------------------------------------
    // stage update
    // ------------------------------------------------------------

    logic [STAGES-1:0] stage;
    logic [STAGES-1:0] next_stage;

    always_comb begin
        case (mode)
            psr_pkg::PSR_SHIFT: begin
                next_stage = {stage[STAGES-2:0], pins.serial};
            end
            psr_pkg::PSR_LOAD: begin
                next_stage = STAGES'(pins.par);
            end
            psr_pkg::PSR_HOLD: begin
                next_stage = stage;
            end
            default: begin
                next_stage = stage;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stage <= `PSR_STAGE_RESET;
        end else if (clr_active) begin
            stage <= '0;
        end else if (fall) begin
            stage <= next_stage;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------

    assign stage0_out = stage[`PSR_STAGE0_BIT];
    assign stage1_out = stage[1];
    assign stage2_out = stage[2];
    assign stage3_out = stage[`PSR_STAGE3_BIT];

    assign stage3_out_inverted = HAS_CLEAR ? !stage[`PSR_STAGE3_BIT] : 1'b0;

    // ------------------------------------------------------------
    // snapshot fifo
    // ------------------------------------------------------------

    logic snap_push;
    logic [3:0] snap_in;

    assign snap_push = fall && !clr_active;
    assign snap_in = 4'(next_stage);

    psr_fifo #(
        .WIDTH(4),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .in_valid(snap_push),
        .in_ready(snap_accept),
        .in_data(snap_in),
        .out_valid(snap_valid),
        .out_ready(snap_ready),
        .out_data(snap_data)
    );

    // sticky lost snapshot flag
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            snap_dropped <= 1'b0;
        end else if (snap_push && !snap_accept) begin
            snap_dropped <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------

    AST_NO_EDGE_STABLE: assert property (@(posedge clk) disable iff (!rst_n)
        !fall && !clr_active |=> $stable(stage))
        else $error("stage changed without falling edge");

    AST_LOAD_COPY: assert property (@(posedge clk) disable iff (!rst_n)
        fall && !clr_active && !pins.shift && pins.load |=> stage == $past(pins.par))
        else $error("load did not copy parallel inputs");

    AST_LOAD_NO_SERIAL: assert property (@(posedge clk) disable iff (!rst_n)
        fall && !clr_active && !pins.shift && pins.load
        |=> stage0_out == $past(pins.par[0]) && stage1_out == $past(pins.par[1]))
        else $error("load took serial or neighbour data");

    AST_SHIFT_OVER_LOAD: assert property (@(posedge clk) disable iff (!rst_n)
        fall && !clr_active && pins.shift && pins.load
        |=> stage[STAGES-1:1] == $past(stage[STAGES-2:0]))
        else $error("load overrode shift");

    AST_SHIFT_RIGHT: assert property (@(posedge clk) disable iff (!rst_n)
        fall && !clr_active && pins.shift
        |=> stage == {$past(stage[STAGES-2:0]), $past(pins.serial)})
        else $error("shift right wrong");

    AST_HOLD_MODE: assert property (@(posedge clk) disable iff (!rst_n)
        fall && !clr_active && !pins.shift && !pins.load |=> $stable(stage))
        else $error("hold mode changed contents");

    AST_CLEAR_ZERO: assert property (@(posedge clk) disable iff (!rst_n)
        clr_active |=> stage == '0 && stage3_out_inverted)
        else $error("clear did not empty stages");

    AST_INVERTED_OUT: assert property (@(posedge clk) disable iff (!rst_n)
        HAS_CLEAR |-> stage3_out_inverted != stage3_out)
        else $error("inverted output does not mirror stage three");

    // basic variant keeps contents through clear pin
    AST_BASIC_NO_CLEAR: assert property (@(posedge clk) disable iff (!rst_n)
        !HAS_CLEAR |-> !clr_active && !stage3_out_inverted)
        else $error("basic variant shows clear behaviour");

    // pin fall detected two cycles after sampling
    AST_PIN_LATENCY: assert property (@(posedge clk) disable iff (!rst_n)
        $fell(reg_clk) ##1 !reg_clk ##1 !reg_clk |-> fall || clr_active)
        else $error("pin edge not seen in time");

    // snapshot flag sets on overflow
    AST_SNAP_DROP: assert property (@(posedge clk) disable iff (!rst_n)
        snap_push && !snap_accept |=> snap_dropped)
        else $error("lost snapshot not flagged");

    AST_RISE_NO_CHANGE: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(pins.reg_clk) && !clr_active |=> $stable(stage))
        else $error("stage changed on rising register clock");

    AST_LOAD_UPPER: assert property (@(posedge clk) disable iff (!rst_n)
        fall && !clr_active && !pins.shift && pins.load
        |=> stage2_out == $past(pins.par[2]) && stage3_out == $past(pins.par[3]))
        else $error("load did not reach upper stages");

    AST_SHIFT_SERIAL_IN: assert property (@(posedge clk) disable iff (!rst_n)
        fall && !clr_active && pins.shift |=> stage0_out == $past(pins.serial))
        else $error("serial level not in first stage");

    AST_SHIFT_CHAIN_OUT: assert property (@(posedge clk) disable iff (!rst_n)
        fall && !clr_active && pins.shift
        |=> stage1_out == $past(stage0_out) && stage2_out == $past(stage1_out)
            && stage3_out == $past(stage2_out))
        else $error("stage outputs did not move right");

    AST_HOLD_OUTPUTS: assert property (@(posedge clk) disable iff (!rst_n)
        fall && !clr_active && !pins.shift && !pins.load
        |=> stage0_out == $past(stage0_out) && stage3_out == $past(stage3_out))
        else $error("hold mode changed outputs");

    AST_CLEAR_OVER_EDGE: assert property (@(posedge clk) disable iff (!rst_n)
        clr_active && fall |=> stage == '0)
        else $error("edge acted during clear");

    // lost snapshot still updates stages
    AST_DROP_KEEPS_UPDATE: assert property (@(posedge clk) disable iff (!rst_n)
        snap_push && !snap_accept |=> stage == $past(next_stage))
        else $error("full fifo blocked the stage update");

    // first snapshot lands at fifo head
    AST_SNAP_HEAD: assert property (@(posedge clk) disable iff (!rst_n)
        snap_push && snap_accept && !snap_valid |=> snap_valid && snap_data == 4'(stage))
        else $error("snapshot head differs from stages");

    // empty fifo stays empty without push
    AST_SNAP_EMPTY: assert property (@(posedge clk) disable iff (!rst_n)
        !snap_valid && !snap_push |=> !snap_valid)
        else $error("snapshot appeared without push");

    // lost snapshot flag is sticky
    AST_DROP_STICKY: assert property (@(posedge clk) disable iff (!rst_n)
        snap_dropped |=> snap_dropped)
        else $error("lost snapshot flag cleared");

endmodule // psr_top

`default_nettype wire

// ### dv/psr_driver.sv
// driving logic model for the shift register pins
`timescale 1ns/1ps
`default_nettype none

module psr_driver (
    // clock
    input wire logic clk,
    // register pins
    output logic reg_clk,
    output logic clear_n,
    output logic shift,
    output logic load,
    output logic serial_in,
    output logic [3:0] par_in
);
    // ----------------------------------------
    // pin sequencing
    // ----------------------------------------
    initial begin
        reg_clk = 1'b0;
        clear_n = 1'b1;
        shift = 1'b0;
        load = 1'b0;
        serial_in = 1'b0;
        par_in = 4'h0;
    end

    task automatic op(input logic s, input logic l, input logic d, input logic [3:0] p);
        @(posedge clk);
        shift <= s;
        load <= l;
        serial_in <= d;
        par_in <= p;
        reg_clk <= 1'b1;
        repeat (4) @(posedge clk);
        reg_clk <= 1'b0;
        repeat (5) @(posedge clk);
        serial_in <= ~d;
        par_in <= ~p;
    endtask

    task automatic clr(input logic v);
        @(posedge clk);
        clear_n <= v;
        repeat (5) @(posedge clk);
    endtask
endmodule // psr_driver

`default_nettype wire

// ### dv/testbench.sv
// self-checking bench for the shift register
`timescale 1ns/1ps
`default_nettype none

module testbench;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic reg_clk, clear_n, shift, load, serial_in;
    logic [3:0] par_in;
    logic s0, s1, s2, s3, s3_inv;
    logic snap_valid, snap_accept, snap_dropped;
    logic snap_ready = 1'b0;
    logic [3:0] snap_data;
    logic stall = 1'b0;
    logic [3:0] mdl = 4'h0;
    logic [3:0] expq[$];
    logic [3:0] w;
    logic b0, b1, b2, b3, b_inv;
    logic [3:0] mdlb = 4'h0;
    int miscompares = 0;
    int checked = 0;

    always #12.5 clk = ~clk;

    psr_driver drv (.clk(clk), .reg_clk(reg_clk), .clear_n(clear_n), .shift(shift), .load(load),
        .serial_in(serial_in), .par_in(par_in));

    psr_top dut (.clk(clk), .rst_n(rst_n), .reg_clk(reg_clk), .clear_n(clear_n), .shift(shift),
        .load(load), .serial_in(serial_in), .par_in(par_in), .stage0_out(s0), .stage1_out(s1),
        .stage2_out(s2), .stage3_out(s3), .stage3_out_inverted(s3_inv), .snap_valid(snap_valid),
        .snap_ready(snap_ready), .snap_data(snap_data), .snap_accept(snap_accept),
        .snap_dropped(snap_dropped));

    psr_top #(.HAS_CLEAR(1'b0)) dut_basic (.clk(clk), .rst_n(rst_n), .reg_clk(reg_clk), .clear_n(clear_n),
        .shift(shift), .load(load), .serial_in(serial_in), .par_in(par_in), .stage0_out(b0), .stage1_out(b1),
        .stage2_out(b2), .stage3_out(b3), .stage3_out_inverted(b_inv), .snap_valid(), .snap_ready(1'b1),
        .snap_data(), .snap_accept(), .snap_dropped());

    // ----------------------------------------
    // checks and model
    // ----------------------------------------
    task automatic chk(input string nm, input logic [3:0] e, input logic [3:0] g);
        checked++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic test_done();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    function automatic logic [3:0] nxt(input logic [3:0] q, input logic s, input logic l, input logic d,
        input logic [3:0] p);
        if (s) begin
            return {q[2:0], d};
        end else if (l) begin
            return p;
        end
        return q;
    endfunction

    task automatic do_op(input logic s, input logic l, input logic d, input logic [3:0] p);
        logic [3:0] prev;
        logic [3:0] prevb;
        prev = mdl;
        prevb = mdlb;
        mdl = nxt(mdl, s, l, d, p);
        mdlb = nxt(mdlb, s, l, d, p);
        if (expq.size() < 8) begin
            expq.push_back(mdl);
        end
        fork
            drv.op(s, l, d, p);
            begin
                repeat (6) @(posedge clk);
                chk("before fall", prev, {s3, s2, s1, s0});
                chk("basic before fall", prevb, {b3, b2, b1, b0});
            end
        join
        chk("stages", mdl, {s3, s2, s1, s0});
        chk("inverted", {3'h0, ~mdl[3]}, {3'h0, s3_inv});
        chk("basic stages", mdlb, {b3, b2, b1, b0});
        chk("basic inverted", 4'h0, {3'h0, b_inv});
    endtask

    always @(posedge clk) begin
        snap_ready <= stall ? 1'b0 : (($urandom % 4) != 0);
        if (rst_n && snap_valid && snap_ready) begin
            w = (expq.size() > 0) ? expq.pop_front() : 4'hX;
            chk("snapshot", w, snap_data);
        end
    end

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        void'($urandom(51958));
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        chk("reset", 4'h0, {s3, s2, s1, s0});
        chk("reset flags", 4'hA, {s3_inv, snap_valid, snap_accept, snap_dropped});
        do_op(1'b0, 1'b1, 1'b1, 4'hA);
        do_op(1'b0, 1'b1, 1'b0, 4'h5);
        do_op(1'b1, 1'b1, 1'b1, 4'h0);
        do_op(1'b1, 1'b0, 1'b0, 4'hF);
        do_op(1'b0, 1'b0, 1'b1, 4'h0);
        do_op(1'b0, 1'b0, 1'b0, 4'hF);
        repeat (60) do_op(1'($urandom), 1'($urandom), 1'($urandom), 4'($urandom));
        drv.clr(1'b0);
        chk("cleared", 4'h0, {s3, s2, s1, s0});
        chk("inv cleared", 4'h1, {3'h0, s3_inv});
        chk("basic kept", mdlb, {b3, b2, b1, b0});
        drv.op(1'b0, 1'b1, 1'b0, 4'hF);
        mdlb = nxt(mdlb, 1'b0, 1'b1, 1'b0, 4'hF);
        chk("clear wins", 4'h0, {s3, s2, s1, s0});
        chk("inv clear wins", 4'h1, {3'h0, s3_inv});
        chk("basic loads", mdlb, {b3, b2, b1, b0});
        drv.clr(1'b1);
        mdl = 4'h0;
        do_op(1'b1, 1'b0, 1'b1, 4'h0);
        repeat (40) @(posedge clk);
        chk("drained", 4'h0, 4'(expq.size()));
        stall <= 1'b1;
        repeat (9) do_op(1'b0, 1'b1, 1'($urandom), 4'($urandom));
        chk("full flags", 4'h1, {2'h0, snap_accept, snap_dropped});
        stall <= 1'b0;
        repeat (60) @(posedge clk);
        chk("empty", 4'h0, {3'h0, snap_valid});
        chk("queue left", 4'h0, 4'(expq.size()));
        test_done();
    end

    initial begin
        #(25 * 20000);
        miscompares++;
        test_done();
    end
endmodule // testbench

`default_nettype wire
